// ### ucmpwm_core.sv
//
// Behaviour
// RULE1 - timers free-run; channels toggle on match
// RULE2 - match when timer count equals compare value
// RULE3 - each match inverts the channel output; code holds the level instead when the next high or low interval is zero
// RULE4 - match advances compare by high or low ticks
// RULE5 - five independent channels sharing two timers
// RULE6 - reset defaults: 20 percent, 1000 Hz
// RULE7 - bytes 0x61-0x65 select channel 0-4
// RULE8 - 0x66/0x67 step duty by ten points
// RULE9 - 0x68/0x69 step frequency by 500 Hz
// RULE10 - 0x6A brackets decimal frequency entry
// RULE11 - 0x6B brackets decimal duty entry
// RULE12 - unknown bytes are dropped without effect
// RULE13 - accepted byte held in pending command register
// RULE14 - compare value changes only at a match
// RULE15 - 9600 baud terminal, 115200 baud gui
// RULE16 - gui mode: apply updates outputs, lights lamp
// RULE17 - 8n1 bytes; ascii digits, msd first
// RULE18 - duty saturates 0-100; frequency kept positive
`timescale 1ns/1ps
module ucmpwm_core #(
    parameter int TW = ucmpwm_pkg::TMR_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic rxd,
    input wire logic guiMode,
    output logic [ucmpwm_pkg::NUM_CH-1:0] pwmOut,
    output logic lampOn
);
    localparam int NC = ucmpwm_pkg::NUM_CH;
    localparam int FW = ucmpwm_pkg::FRQ_W;
    localparam int DW = ucmpwm_pkg::DUTY_W;
    localparam int AW = ucmpwm_pkg::ACC_W;

    typedef enum logic [1:0] {ST_IDLE, ST_DIVP, ST_DIVH} ucmpwm_st_e;
    typedef enum logic [1:0] {ENT_NONE, ENT_FREQ, ENT_DUTY} ucmpwm_ent_e;
    // all core state
    typedef struct packed {
        ucmpwm_st_e st; // command sequencer
        ucmpwm_ent_e ent; // open digit entry, if any
        logic [1:0][TW-1:0] tmr; // two free-running timers
        logic [NC-1:0][TW-1:0] cmp; // compare points
        logic [NC-1:0] lvl; // output levels
        logic [NC-1:0][TW-1:0] hiT; // live high ticks
        logic [NC-1:0][TW-1:0] loT; // live low ticks
        logic [NC-1:0][TW-1:0] hiS; // staged high ticks
        logic [NC-1:0][TW-1:0] loS; // staged low ticks
        logic [NC-1:0][FW-1:0] freq; // hertz per channel
        logic [NC-1:0][DW-1:0] duty; // percent per channel
        logic [2:0] sel; // channel being edited
        logic [7:0] pend; // pending command byte
        logic pendV; // pending command present
        logic [AW-1:0] acc; // decimal accumulator
        logic [31:0] num; // dividend, then quotient
        logic [TW:0] rem; // partial remainder
        logic [TW-1:0] den; // divisor
        logic [4:0] dcnt; // divider step
        logic [TW-1:0] period; // ticks per period
        logic lamp; // apply acknowledge
    } ucmpwm_s;
    ucmpwm_s s_q;
    ucmpwm_s s_d;

    ucmpwm_rx_if rxIf ();
    logic [NC-1:0] hit; // per-channel compare match

    // channel select byte
    function automatic logic isSel(input logic [7:0] b);
        return (b >= ucmpwm_pkg::CMD_SEL_FIRST) && (b <= ucmpwm_pkg::CMD_SEL_LAST);
    endfunction

    // ascii decimal digit
    function automatic logic isDigit(input logic [7:0] b);
        return (b >= ucmpwm_pkg::DIGIT_0) && (b <= ucmpwm_pkg::DIGIT_9);
    endfunction

    // bytes worth keeping; digits only while an entry is open
    function automatic logic accept(input logic [7:0] b, input ucmpwm_ent_e e);
        return ((b >= ucmpwm_pkg::CMD_SEL_FIRST) && (b <= ucmpwm_pkg::CMD_APPLY))
            || ((e != ENT_NONE) && isDigit(b));
    endfunction

    // serial bit time follows the operating mode
    assign rxIf.bitCycles = guiMode ? ucmpwm_pkg::BIT_CYC_GUI : ucmpwm_pkg::BIT_CYC_TERM; // RULE15

    // byte receiver, 8n1
    ucmpwm_uart_rx uRx (
        .clk(clk),
        .srst(srst),
        .rxd(rxd), // RULE17
        .rxPort(rxIf.rx)
    );

    // channels 0-2 watch the first timer, 3-4 the second
    for (genvar g = 0; g < NC; g++) begin : gHit
        localparam int TIDX = (g < ucmpwm_pkg::FIRST_TMR_CH) ? 0 : 1;
        assign hit[g] = (s_q.cmp[g] == s_q.tmr[TIDX]); // RULE2 RULE5
    end

    // next-state logic
    always_comb begin
        logic nxt;
        logic go;
        logic qBit;
        logic [TW:0] remSh;
        logic [31:0] quo;
        logic [TW-1:0] hiNew;
        logic [FW-1:0] f;
        logic [DW-1:0] d;
        nxt = 1'b0;
        go = 1'b0;
        qBit = 1'b0;
        remSh = '0;
        quo = '0;
        hiNew = '0;
        f = s_q.freq[s_q.sel];
        d = s_q.duty[s_q.sel];
        s_d = s_q;

        // timers never stop or reload
        for (int t = 0; t < 2; t++) begin
            s_d.tmr[t] = s_q.tmr[t] + TW'(1); // RULE1
        end

        // toggle and re-arm; a zero interval pins the level instead
        for (int c = 0; c < NC; c++) begin
            if (hit[c]) begin
                nxt = ~s_q.lvl[c]; // RULE3
                if (nxt && s_q.hiT[c] == '0) begin
                    nxt = 1'b0;
                end else if (!nxt && s_q.loT[c] == '0) begin
                    nxt = 1'b1;
                end
                s_d.lvl[c] = nxt;
                s_d.cmp[c] = s_q.cmp[c] + (nxt ? s_q.hiT[c] : s_q.loT[c]); // RULE4 RULE14
            end
        end

        // pending command is consumed by the idle sequencer
        if (s_q.st == ST_IDLE && s_q.pendV) begin
            s_d.pendV = 1'b0;
        end
        // a new byte in the same cycle wins over the consume
        if (rxIf.rxValid && accept(rxIf.rxByte, s_q.ent)) begin // RULE12
            s_d.pend = rxIf.rxByte; // RULE13
            s_d.pendV = 1'b1;
        end

        unique case (s_q.st)
            ST_IDLE: begin
                if (s_q.pendV) begin
                    s_d.lamp = 1'b0;
                    if (isSel(s_q.pend)) begin
                        s_d.sel = 3'(s_q.pend - ucmpwm_pkg::CMD_SEL_FIRST); // RULE7
                    end else if (s_q.pend == ucmpwm_pkg::CMD_DUTY_UP) begin
                        s_d.duty[s_q.sel] = (d > ucmpwm_pkg::DUTY_MAX - ucmpwm_pkg::DUTY_STEP)
                            ? ucmpwm_pkg::DUTY_MAX : d + ucmpwm_pkg::DUTY_STEP; // RULE8 RULE18
                        go = 1'b1;
                    end else if (s_q.pend == ucmpwm_pkg::CMD_DUTY_DOWN) begin
                        s_d.duty[s_q.sel] = (d < ucmpwm_pkg::DUTY_STEP)
                            ? '0 : d - ucmpwm_pkg::DUTY_STEP; // RULE8 RULE18
                        go = 1'b1;
                    end else if (s_q.pend == ucmpwm_pkg::CMD_FREQ_UP) begin
                        s_d.freq[s_q.sel] = (f > ucmpwm_pkg::FREQ_MAX - ucmpwm_pkg::FREQ_STEP)
                            ? ucmpwm_pkg::FREQ_MAX : f + ucmpwm_pkg::FREQ_STEP; // RULE9
                        go = 1'b1;
                    end else if (s_q.pend == ucmpwm_pkg::CMD_FREQ_DOWN) begin
                        s_d.freq[s_q.sel] = (f < ucmpwm_pkg::FREQ_MIN + ucmpwm_pkg::FREQ_STEP)
                            ? ucmpwm_pkg::FREQ_MIN : f - ucmpwm_pkg::FREQ_STEP; // RULE9 RULE18
                        go = 1'b1;
                    end else if (s_q.pend == ucmpwm_pkg::CMD_FREQ_ENTRY) begin
                        if (s_q.ent == ENT_FREQ) begin
                            // closing delimiter: clamp into the usable range
                            if (s_q.acc < AW'(ucmpwm_pkg::FREQ_MIN)) begin
                                s_d.freq[s_q.sel] = ucmpwm_pkg::FREQ_MIN; // RULE18
                            end else if (s_q.acc > AW'(ucmpwm_pkg::FREQ_MAX)) begin
                                s_d.freq[s_q.sel] = ucmpwm_pkg::FREQ_MAX;
                            end else begin
                                s_d.freq[s_q.sel] = FW'(s_q.acc); // RULE10
                            end
                            s_d.ent = ENT_NONE;
                            go = 1'b1;
                        end else begin
                            // opening delimiter; abandons any duty entry
                            s_d.ent = ENT_FREQ; // RULE10
                            s_d.acc = '0;
                        end
                    end else if (s_q.pend == ucmpwm_pkg::CMD_DUTY_ENTRY) begin
                        if (s_q.ent == ENT_DUTY) begin
                            s_d.duty[s_q.sel] = (s_q.acc > AW'(ucmpwm_pkg::DUTY_MAX))
                                ? ucmpwm_pkg::DUTY_MAX : DW'(s_q.acc); // RULE11 RULE18
                            s_d.ent = ENT_NONE;
                            go = 1'b1;
                        end else begin
                            s_d.ent = ENT_DUTY; // RULE11
                            s_d.acc = '0;
                        end
                    end else if (s_q.pend == ucmpwm_pkg::CMD_APPLY) begin
                        // staged ticks go live together; ignored in terminal mode
                        if (guiMode) begin
                            s_d.hiT = s_q.hiS; // RULE16
                            s_d.loT = s_q.loS;
                            s_d.lamp = 1'b1;
                        end
                    end else if (isDigit(s_q.pend)) begin
                        // most significant digit first; stops growing at the cap
                        if (s_q.acc < ucmpwm_pkg::ACC_CAP) begin
                            s_d.acc = AW'(s_q.acc * AW'(10)
                                + AW'(s_q.pend - ucmpwm_pkg::DIGIT_0)); // RULE17
                        end
                    end
                    if (go) begin
                        // period = clock rate / frequency
                        s_d.st = ST_DIVP; // RULE4
                        s_d.num = 32'(ucmpwm_pkg::CLK_HZ);
                        s_d.den = TW'(s_d.freq[s_q.sel]);
                        s_d.rem = '0;
                        s_d.dcnt = '0;
                    end
                end
            end
            ST_DIVP, ST_DIVH: begin
                // one restoring division step per clock; 32 steps per divide
                remSh = {s_q.rem[TW-1:0], s_q.num[31]};
                qBit = (remSh >= {1'b0, s_q.den});
                s_d.rem = qBit ? remSh - {1'b0, s_q.den} : remSh;
                s_d.num = {s_q.num[30:0], qBit};
                s_d.dcnt = s_q.dcnt + 5'h01;
                if (s_q.dcnt == ucmpwm_pkg::DIV_LAST) begin
                    quo = {s_q.num[30:0], qBit};
                    if (s_q.st == ST_DIVP) begin
                        // high ticks = period * duty / 100
                        s_d.period = quo[TW-1:0];
                        s_d.st = ST_DIVH;
                        s_d.num = 32'(quo[TW-1:0]) * 32'(s_q.duty[s_q.sel]);
                        s_d.den = TW'(ucmpwm_pkg::DUTY_MAX);
                        s_d.rem = '0;
                        s_d.dcnt = '0;
                    end else begin
                        // in terminal mode live ticks change now, the compare only at its next match; gui mode only stages them
                        hiNew = quo[TW-1:0];
                        s_d.hiS[s_q.sel] = hiNew;
                        s_d.loS[s_q.sel] = s_q.period - hiNew;
                        if (!guiMode) begin
                            s_d.hiT[s_q.sel] = hiNew; // RULE14 RULE16
                            s_d.loT[s_q.sel] = s_q.period - hiNew;
                        end
                        s_d.st = ST_IDLE;
                    end
                end
            end
        endcase

        // synchronous reset to the power-on waveform
        if (srst) begin
            s_d = '0;
            s_d.freq = {NC{ucmpwm_pkg::FREQ_INIT}}; // RULE6
            s_d.duty = {NC{ucmpwm_pkg::DUTY_INIT}};
            s_d.hiT = {NC{TW'(ucmpwm_pkg::HIGH_INIT)}};
            s_d.loT = {NC{TW'(ucmpwm_pkg::LOW_INIT)}};
            s_d.hiS = {NC{TW'(ucmpwm_pkg::HIGH_INIT)}};
            s_d.loS = {NC{TW'(ucmpwm_pkg::LOW_INIT)}};
            s_d.cmp = {NC{TW'(ucmpwm_pkg::HIGH_INIT)}};
            s_d.lvl = '1;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign pwmOut = s_q.lvl;
    assign lampOn = s_q.lamp;

    // checks
    default clocking cbMain @(posedge clk); endclocking
    default disable iff (srst);

    sequence seqSelTaken;
        s_q.st == ST_IDLE && s_q.pendV && isSel(s_q.pend);
    endsequence
    sequence seqDutyUp;
        s_q.st == ST_IDLE && s_q.pendV && s_q.pend == ucmpwm_pkg::CMD_DUTY_UP;
    endsequence
    sequence seqApply;
        s_q.st == ST_IDLE && s_q.pendV && s_q.pend == ucmpwm_pkg::CMD_APPLY && guiMode;
    endsequence

    AST_FREE_RUN: // RULE1
    assert property (!$past(srst) |-> s_q.tmr[1] == $past(s_q.tmr[1]) + TW'(1))
        else $error("timer did not advance by one");
    AST_TOGGLE: // RULE3
    assert property (hit[0] && s_q.hiT[0] != '0 && s_q.loT[0] != '0
        |=> pwmOut[0] != $past(pwmOut[0]))
        else $error("channel 0 did not toggle on its match");
    AST_ADVANCE: // RULE4
    assert property (hit[1] && !s_q.lvl[1] && s_q.hiT[1] != '0
        |=> s_q.cmp[1] == $past(s_q.cmp[1]) + $past(s_q.hiT[1]))
        else $error("compare not advanced by high ticks");
    AST_CMP_HOLD: // RULE14
    assert property (!hit[3] |=> $stable(s_q.cmp[3]))
        else $error("compare changed without a match");
    AST_DEFAULTS: // RULE6
    assert property ($past(srst) |-> s_q.freq[2] == ucmpwm_pkg::FREQ_INIT
        && s_q.duty[2] == ucmpwm_pkg::DUTY_INIT && s_q.hiT[2] == ucmpwm_pkg::HIGH_INIT)
        else $error("reset defaults wrong");
    AST_SELECT: // RULE7
    assert property (seqSelTaken |=> s_q.sel == 3'($past(s_q.pend) - ucmpwm_pkg::CMD_SEL_FIRST))
        else $error("wrong channel selected");
    AST_DISCARD: // RULE12
    assert property (rxIf.rxValid && !s_q.pendV
        && !(rxIf.rxByte inside {[ucmpwm_pkg::CMD_SEL_FIRST:ucmpwm_pkg::CMD_APPLY]})
        && !(s_q.ent != ENT_NONE
        && rxIf.rxByte inside {[ucmpwm_pkg::DIGIT_0:ucmpwm_pkg::DIGIT_9]})
        |=> !s_q.pendV)
        else $error("invalid byte was latched");
    AST_DUTY_BOUND: // RULE18
    assert property (s_q.duty[s_q.sel] <= ucmpwm_pkg::DUTY_MAX)
        else $error("duty above 100 percent");
    AST_RECALC: // RULE8
    assert property (seqDutyUp |=> (s_q.st != ST_IDLE) [*8] ##[1:70] s_q.st == ST_IDLE)
        else $error("duty step recompute did not finish in time");
    AST_LAMP: // RULE16
    assert property (seqApply |=> lampOn && s_q.hiT == $past(s_q.hiS) ##1 $stable(s_q.hiT))
        else $error("apply not acknowledged");
    // waveform checks; the second timer feeds channel 4
    AST_MATCH: // RULE2
    assert property (s_q.cmp[4] == s_q.tmr[1] |=> s_q.cmp[4] != $past(s_q.cmp[4]))
        else $error("channel 4 compare not re-armed at its match");
    AST_PIN_HIGH: // RULE18
    assert property (hit[2] && s_q.lvl[2] && s_q.loT[2] == '0 |=> pwmOut[2])
        else $error("full duty channel left the high level");
    // command path checks
    AST_LATCH: // RULE13
    assert property (rxIf.rxValid
        && rxIf.rxByte inside {[ucmpwm_pkg::CMD_SEL_FIRST:ucmpwm_pkg::CMD_APPLY]}
        |=> s_q.pendV && s_q.pend == $past(rxIf.rxByte))
        else $error("command byte not held as pending");
    AST_STAGED: // RULE16
    assert property (guiMode && s_q.st == ST_DIVH && s_q.dcnt == ucmpwm_pkg::DIV_LAST
        |=> $stable(s_q.hiT) && $stable(s_q.loT))
        else $error("gui timings went live before apply");
endmodule

// ### ucmpwm_core_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the five channel pwm block
module ucmpwm_core_tb_top;
    logic clk; // 10 mhz system clock
    logic srst; // synchronous reset
    logic guiMode; // link mode select
    logic rxd; // serial line from the host
    logic [ucmpwm_pkg::NUM_CH-1:0] pwmOut; // pwm outputs
    logic lampOn; // apply lamp
    int errCount; // mismatches seen
    int cmpCount; // comparisons made
    logic [31:0] rngQ; // xorshift state

    ucmpwm_core ucmpwm_core_inst (
        .clk(clk),
        .srst(srst),
        .rxd(rxd),
        .guiMode(guiMode),
        .pwmOut(pwmOut),
        .lampOn(lampOn)
    );

    ucmpwm_host_model ucmpwm_host_model_inst (
        .clk(clk),
        .guiMode(guiMode),
        .rxd(rxd)
    );

    // free-running clock
    initial clk = 1'b0;
    always #50 clk = ~clk;

    // xorshift step, seeded once below
    function automatic logic [31:0] nextRand(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    // high ticks: whole clocks per period, then the percent share
    function automatic logic [31:0] expHigh(input int hz, input int pct);
        return 32'(ucmpwm_pkg::CLK_HZ / hz * pct / 100);
    endfunction

    // low ticks: the rest of the period
    function automatic logic [31:0] expLow(input int hz, input int pct);
        return 32'(ucmpwm_pkg::CLK_HZ / hz) - expHigh(hz, pct);
    endfunction

    // byte outside every command and digit code
    function automatic logic [7:0] junkByte(input logic [31:0] x);
        logic [7:0] b;
        b = x[7:0];
        if (b >= 8'h30 && b <= 8'h6F) begin
            b = b | 8'h80;
        end
        return b;
    endfunction

    task automatic chkCnt(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            errCount++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        cmpCount++;
        if (got !== exp) begin
            errCount++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // commands and digits as their keyboard characters
    task automatic sendStr(input string s);
        for (int i = 0; i < s.len(); i++) begin
            ucmpwm_host_model_inst.sendByte(8'(s[i]));
        end
        // let the sequencer and the divider finish; end off the edge
        repeat (100) @(negedge clk);
    endtask

    // skips to a fresh rising edge, then times one high and one low run
    task automatic measure(input int ch, input int hz, input int pct);
        logic [31:0] hi;
        logic [31:0] lo;
        hi = 32'h0000_0000;
        lo = 32'h0000_0000;
        @(negedge clk);
        while (pwmOut[ch] !== 1'b0) @(negedge clk);
        while (pwmOut[ch] !== 1'b1) @(negedge clk);
        while (pwmOut[ch] === 1'b1) begin
            hi++;
            @(negedge clk);
        end
        while (pwmOut[ch] === 1'b0) begin
            lo++;
            @(negedge clk);
        end
        chkCnt(hi, expHigh(hz, pct));
        chkCnt(lo, expLow(hz, pct));
    endtask

    // single place where the run ends
    task automatic results();
        if (errCount == 0 && cmpCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog: whole plan needs roughly 100k cycles
    initial begin
        #(130_000 * 100);
        errCount++;
        results();
    end

    // main sequence
    initial begin
        errCount = 0;
        cmpCount = 0;
        rngQ = 32'h0000_915B;
        srst = 1'b1;
        guiMode = 1'b0;
        repeat (20) @(posedge clk);
        #1 srst = 1'b0;
        chkBit(&pwmOut, 1'b1);
        chkBit(lampOn, 1'b0);
        measure(0, 1000, 20);
        // gui mode: timings wait for the apply byte
        @(posedge clk);
        #1 guiMode = 1'b1;
        repeat (10) @(posedge clk);
        sendStr("cf");
        chkBit(lampOn, 1'b0);
        sendStr("l");
        chkBit(lampOn, 1'b1);
        rngQ = nextRand(rngQ);
        ucmpwm_host_model_inst.sendByte(junkByte(rngQ));
        rngQ = nextRand(rngQ);
        ucmpwm_host_model_inst.sendByte(junkByte(rngQ));
        repeat (100) @(negedge clk);
        chkBit(lampOn, 1'b1);
        measure(2, 1000, 30);
        // frequency entry 4500, two steps up and one down gives 5000 hz
        sendStr("j4500jhhi");
        chkBit(lampOn, 1'b0);
        sendStr("l");
        measure(2, 5000, 30);
        // duty entry 50 then one step down gives 40 percent
        sendStr("k50kgl");
        measure(2, 5000, 40);
        // 95 plus a step saturates at 100: output pinned high
        sendStr("k95kfl");
        repeat (2500) @(posedge clk);
        @(negedge clk);
        chkBit(pwmOut[2], 1'b1);
        repeat (1100) @(negedge clk);
        chkBit(pwmOut[2], 1'b1);
        // terminal mode acts at once; last channel to 10 percent
        @(posedge clk);
        #1 guiMode = 1'b0;
        repeat (10) @(posedge clk);
        sendStr("eg");
        measure(4, 1000, 10);
        results();
    end
endmodule

// ### ucmpwm_host_model.sv
`timescale 1ns/1ps
// host side of the serial link: a plain byte transmitter
module ucmpwm_host_model (
    input wire logic clk,
    input wire logic guiMode,
    output logic rxd
);
    // line idles high, like a released uart pin with its pull-up
    initial begin
        rxd = 1'b1;
    end

    // one 8n1 frame, lsb first; bit time follows the link mode
    task automatic sendByte(input logic [7:0] b);
        int bitCyc; // clocks per bit for the current mode
        logic [9:0] frame; // stop, data, start
        bitCyc = guiMode ? int'(ucmpwm_pkg::BIT_CYC_GUI) : int'(ucmpwm_pkg::BIT_CYC_TERM);
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1 rxd = frame[i];
            repeat (bitCyc - 1) @(posedge clk);
        end
        // leave the stop level standing as idle
    endtask
endmodule

// ### ucmpwm_pkg.sv
package ucmpwm_pkg;
    // clock and serial timing
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int BAUD_TERM = 9600;
    localparam int BAUD_GUI = 115200;
    localparam logic [15:0] BIT_CYC_TERM = 16'(CLK_HZ / BAUD_TERM);
    localparam logic [15:0] BIT_CYC_GUI = 16'(CLK_HZ / BAUD_GUI);
    // datapath widths
    localparam int TMR_W = 20;
    localparam int FRQ_W = 17;
    localparam int DUTY_W = 7;
    localparam int ACC_W = 20;
    localparam int NUM_CH = 5;
    localparam int FIRST_TMR_CH = 3;
    // command bytes
    localparam logic [7:0] CMD_SEL_FIRST = 8'h61;
    localparam logic [7:0] CMD_SEL_LAST = 8'h65;
    localparam logic [7:0] CMD_DUTY_UP = 8'h66;
    localparam logic [7:0] CMD_DUTY_DOWN = 8'h67;
    localparam logic [7:0] CMD_FREQ_UP = 8'h68;
    localparam logic [7:0] CMD_FREQ_DOWN = 8'h69;
    localparam logic [7:0] CMD_FREQ_ENTRY = 8'h6A;
    localparam logic [7:0] CMD_DUTY_ENTRY = 8'h6B;
    localparam logic [7:0] CMD_APPLY = 8'h6C;
    localparam logic [7:0] DIGIT_0 = 8'h30;
    localparam logic [7:0] DIGIT_9 = 8'h39;
    // duty and frequency limits, percent and hertz
    localparam int FREQ_INIT_HZ = 1000;
    localparam int DUTY_INIT_PCT = 20;
    localparam logic [FRQ_W-1:0] FREQ_INIT = FRQ_W'(FREQ_INIT_HZ);
    localparam logic [FRQ_W-1:0] FREQ_STEP = FRQ_W'(500);
    localparam logic [FRQ_W-1:0] FREQ_MIN = FRQ_W'(10);
    localparam logic [FRQ_W-1:0] FREQ_MAX = FRQ_W'(50000);
    localparam logic [DUTY_W-1:0] DUTY_INIT = DUTY_W'(DUTY_INIT_PCT);
    localparam logic [DUTY_W-1:0] DUTY_STEP = DUTY_W'(10);
    localparam logic [DUTY_W-1:0] DUTY_MAX = DUTY_W'(100);
    localparam logic [ACC_W-1:0] ACC_CAP = ACC_W'(100000);
    // default tick counts
    localparam logic [TMR_W-1:0] PERIOD_INIT = TMR_W'(CLK_HZ / FREQ_INIT_HZ);
    localparam logic [TMR_W-1:0] HIGH_INIT = TMR_W'(CLK_HZ / FREQ_INIT_HZ * DUTY_INIT_PCT / 100);
    localparam logic [TMR_W-1:0] LOW_INIT = PERIOD_INIT - HIGH_INIT;
    // shared divider
    localparam logic [4:0] DIV_LAST = 5'h1F;
endpackage

// ### ucmpwm_rx_if.sv
`timescale 1ns/1ps
// received bytes travel one way, the bit time the other
interface ucmpwm_rx_if;
    logic [7:0] rxByte; // last good byte
    logic rxValid; // one-cycle strobe
    logic [15:0] bitCycles; // clocks per serial bit
    modport rx (output rxByte, output rxValid, input bitCycles);
    modport ctl (input rxByte, input rxValid, output bitCycles);
endinterface

// ### ucmpwm_uart_rx.sv
`timescale 1ns/1ps
module ucmpwm_uart_rx (
    input wire logic clk,
    input wire logic srst,
    input wire logic rxd,
    ucmpwm_rx_if.rx rxPort
);
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ucmpwm_rxst_e;
    // whole receiver state
    typedef struct packed {
        ucmpwm_rxst_e st;
        logic [15:0] cnt; // down counter to next sample
        logic [2:0] bitIdx; // data bit number
        logic [7:0] shift; // lsb first assembly
        logic [7:0] data; // held output byte
        logic valid; // output strobe
    } ucmpwm_rx_s;
    ucmpwm_rx_s s_q;
    ucmpwm_rx_s s_d;

    // 8n1 framing, sample mid-bit
    always_comb begin
        s_d = s_q;
        s_d.valid = 1'b0;
        unique case (s_q.st)
            RX_IDLE: begin
                // falling edge starts a frame; wait half a bit
                if (!rxd) begin
                    s_d.st = RX_START;
                    s_d.cnt = {1'b0, rxPort.bitCycles[15:1]};
                end
            end
            RX_START: begin
                if (s_q.cnt != 16'h0000) begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end else if (!rxd) begin
                    s_d.st = RX_DATA;
                    s_d.bitIdx = 3'h0;
                    s_d.cnt = rxPort.bitCycles - 16'h0001;
                end else begin
                    // glitch, not a start bit
                    s_d.st = RX_IDLE;
                end
            end
            RX_DATA: begin
                if (s_q.cnt != 16'h0000) begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end else begin
                    s_d.shift = {rxd, s_q.shift[7:1]};
                    s_d.cnt = rxPort.bitCycles - 16'h0001;
                    s_d.bitIdx = s_q.bitIdx + 3'h1;
                    if (s_q.bitIdx == 3'h7) begin
                        s_d.st = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (s_q.cnt != 16'h0000) begin
                    s_d.cnt = s_q.cnt - 16'h0001;
                end else begin
                    // a low stop bit is a framing error: byte dropped
                    if (rxd) begin
                        s_d.data = s_q.shift;
                        s_d.valid = 1'b1;
                    end
                    s_d.st = RX_IDLE;
                end
            end
        endcase
        if (srst) begin
            s_d = '0;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign rxPort.rxByte = s_q.data;
    assign rxPort.rxValid = s_q.valid;
endmodule
